// ==== rtl/i2c_target_ports.sv ====
// target end: fifo, per-port protocol engine and two-port top
`timescale 1ns/1ns
module i2c_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	input  wire logic         ref_clk_in,
	input  wire logic         resetn_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;
	logic [AW:0]  fill;
	// honest full and empty from pointer distance
	assign fill          = wp_q - rp_q;
	assign in_ready_out  = (fill != (AW + 1)'(D));
	assign out_valid_out = (fill != '0);
	assign out_data_out  = mem_q[rp_q[AW-1:0]];
	// storage writes
	always_ff @(posedge ref_clk_in)
		if (in_valid_in && in_ready_out)
			mem_q[wp_q[AW-1:0]] <= in_data_in;
	// pointers
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (in_valid_in && in_ready_out)
				wp_q <= wp_q + 1'b1;
			if (out_valid_out && out_ready_in)
				rp_q <= rp_q + 1'b1;
		end
endmodule

module i2c_target_engine (
	input  wire logic   ref_clk_in,
	input  wire logic   resetn_in,
	i2c_link_if.target  link,
	input  wire logic   en_in,
	input  wire logic [6:0] own_addr_in,
	input  wire logic [6:0] addr_mask_in,
	output logic [7:0]  rd_sub_out,
	input  wire logic [7:0] rd_data_in,
	output logic        wr_valid_out,
	input  wire logic   wr_ready_in,
	output logic [15:0] wr_word_out
);
	import i2c_link_pkg::*;
	logic scl1, scl2, scl3, sda1, sda2, sda3;
	logic start_c, stop_c, rise, fall, match, fin_ready, push, rx_go;
	tgt_t st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] sub_q;
	logic have_sub_q, rw_q, ack_q, scl_oe_q, sda_oe_q;
	// two-stage synchronisers plus one edge stage
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
		begin
			{scl1, scl2, scl3} <= 3'h7;
			{sda1, sda2, sda3} <= 3'h7;
		end
		else
		begin
			{scl1, scl2, scl3} <= {link.scl, scl1, scl2};
			{sda1, sda2, sda3} <= {link.sda, sda1, sda2};
		end
	// line conditions, data moving with clock high is a control
	assign start_c = scl2 & scl3 & sda3 & ~sda2;
	assign stop_c  = scl2 & scl3 & ~sda3 & sda2;
	assign rise    = scl2 & ~scl3;
	assign fall    = ~scl2 & scl3;
	// masked address compare
	assign match = (((sh_q[7:1] ^ own_addr_in) & ~addr_mask_in) == 7'h00);
	// data byte waits for fifo room, sub-address byte never does
	assign rx_go = (st_q == T_RX) && (bit_q == BYTE_BITS) && !scl2
		&& (!have_sub_q || fin_ready);
	assign push  = rx_go && have_sub_q;
	assign rd_sub_out    = sub_q;
	assign link.t_scl_o  = 1'b0;
	assign link.t_sda_o  = 1'b0;
	assign link.t_scl_oe = scl_oe_q;
	assign link.t_sda_oe = sda_oe_q;
	// protocol state machine, clock-edge driven at any bus speed
	always_ff @(posedge ref_clk_in)
		if (!resetn_in || !en_in)
		begin
			st_q       <= T_IDLE;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			sub_q      <= 8'h00;
			have_sub_q <= 1'b0;
			rw_q       <= 1'b0;
			ack_q      <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
		end
		else if (start_c)
		begin
			st_q       <= T_ADDR;  // repeated start keeps sub-address
			bit_q      <= 4'h0;
			have_sub_q <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
		end
		else if (stop_c)
		begin
			st_q     <= T_IDLE;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
			case (st_q)
				T_IDLE: ;
				T_ADDR:
					if (rise && bit_q != BYTE_BITS)
					begin
						sh_q  <= {sh_q[6:0], sda2};
						bit_q <= bit_q + 4'h1;
					end
					else if (fall && bit_q == BYTE_BITS)
					begin
						if (match)
						begin
							sda_oe_q <= 1'b1;
							rw_q     <= sh_q[0];
							st_q     <= T_AACK;
						end
						else
							st_q <= T_IDLE;
					end
				T_AACK:
					if (fall)
					begin
						bit_q <= 4'h0;
						if (rw_q)
						begin
							tx_q     <= rd_data_in;
							sda_oe_q <= ~rd_data_in[7];
							sub_q    <= sub_q + 8'h01;
							st_q     <= T_TX;
						end
						else
						begin
							sda_oe_q <= 1'b0;
							st_q     <= T_RX;
						end
					end
				T_RX:
					if (rise && bit_q != BYTE_BITS)
					begin
						sh_q  <= {sh_q[6:0], sda2};
						bit_q <= bit_q + 4'h1;
					end
					else if (rx_go)
					begin
						sda_oe_q <= 1'b1;
						st_q     <= T_RACK;
						have_sub_q <= 1'b1;
						if (have_sub_q)
							sub_q <= sub_q + 8'h01;
						else
							sub_q <= sh_q;
					end
					else if (bit_q == BYTE_BITS && !scl2)
						scl_oe_q <= 1'b1;
				T_RACK:
					if (fall)
					begin
						sda_oe_q <= 1'b0;
						bit_q    <= 4'h0;
						st_q     <= T_RX;
					end
					else
						scl_oe_q <= 1'b0;  // ack settles a cycle before a stretch ends
				T_TX:
					if (rise)
						bit_q <= bit_q + 4'h1;
					else if (fall)
					begin
						if (bit_q == BYTE_BITS)
						begin
							sda_oe_q <= 1'b0;
							st_q     <= T_TACK;
						end
						else
						begin
							sda_oe_q <= ~tx_q[6];
							tx_q     <= {tx_q[6:0], 1'b0};
						end
					end
				T_TACK:
					if (rise)
						ack_q <= ~sda2;
					else if (fall)
					begin
						bit_q <= 4'h0;
						if (ack_q)
						begin
							tx_q     <= rd_data_in;
							sda_oe_q <= ~rd_data_in[7];
							sub_q    <= sub_q + 8'h01;
							st_q     <= T_TX;
						end
						else
							st_q <= T_IDLE;
					end
				default: st_q <= T_IDLE;
			endcase
	// written bytes leave as {sub-address, data}
	i2c_fifo #(.W(16), .D(4)) u_fifo (
		.ref_clk_in    (ref_clk_in),
		.resetn_in     (resetn_in),
		.in_valid_in   (push),
		.in_ready_out  (fin_ready),
		.in_data_in    ({sub_q, sh_q}),
		.out_valid_out (wr_valid_out),
		.out_ready_in  (wr_ready_in),
		.out_data_out  (wr_word_out)
	);
endmodule

module i2c_target_ports #(
	parameter int DEPTH = 16,
	parameter int EVW   = 8
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 resetn_in,
	i2c_link_if.target                first_target_port,
	i2c_link_if.target                second_target_port,
	input  wire logic [7:0]           address_select_analog_pin_in,
	input  wire logic                 port_en_in,
	input  wire logic [1:0][6:0]      addr_mask_in,
	input  wire logic                 reg_wr_en_in,
	input  wire logic [7:0]           reg_wr_idx_in,
	input  wire logic [7:0]           reg_wr_data_in,
	output logic [1:0]                wr_valid_out,
	input  wire logic [1:0]           wr_ready_in,
	output logic [1:0][15:0]          wr_word_out,
	input  wire logic [EVW-1:0]       event_in,
	input  wire logic [1:0][EVW-1:0]  irq_mask_in,
	output logic [1:0]                irq_out
);
	import i2c_link_pkg::*;
	localparam int IW = $clog2(DEPTH);
	logic [7:0] regs_q [DEPTH];
	logic [2:0] code_d;
	logic [2:0] code_q;
	logic [1:0][7:0] rd_sub;
	logic [1:0][7:0] rd_data;
	logic [1:0] irq_q;
	// divider ratio to three-bit code: count band edges passed
	always_comb
	begin
		code_d = 3'h0;
		for (int i = 0; i < 7; i++)
			if (address_select_analog_pin_in >= DEC_THR[i])
				code_d = code_d + 3'h1;
	end
	// code follows the pin only until the ports are enabled
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
			code_q <= 3'h0;
		else if (!port_en_in)
			code_q <= code_d;
	// command registers, loaded by the core, read by either port
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
			for (int i = 0; i < DEPTH; i++)
				regs_q[i] <= 8'h00;
		else if (reg_wr_en_in && reg_wr_idx_in < 8'(DEPTH))
			regs_q[reg_wr_idx_in[IW-1:0]] <= reg_wr_data_in;
	// sub-address selects register, beyond the array reads zero
	always_comb
		for (int p = 0; p < 2; p++)
			rd_data[p] = (rd_sub[p] < 8'(DEPTH)) ? regs_q[rd_sub[p][IW-1:0]] : 8'h00;
	// per-port interrupt masking
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
			irq_q <= 2'h0;
		else
			for (int p = 0; p < 2; p++)
				irq_q[p] <= |(event_in & irq_mask_in[p]);
	assign irq_out = irq_q;
	i2c_target_engine u_first (
		.ref_clk_in   (ref_clk_in),
		.resetn_in    (resetn_in),
		.link         (first_target_port),
		.en_in        (port_en_in),
		.own_addr_in  ({ADDR1_PREFIX, code_q}),
		.addr_mask_in (addr_mask_in[0]),
		.rd_sub_out   (rd_sub[0]),
		.rd_data_in   (rd_data[0]),
		.wr_valid_out (wr_valid_out[0]),
		.wr_ready_in  (wr_ready_in[0]),
		.wr_word_out  (wr_word_out[0])
	);
	i2c_target_engine u_second (
		.ref_clk_in   (ref_clk_in),
		.resetn_in    (resetn_in),
		.link         (second_target_port),
		.en_in        (port_en_in),
		.own_addr_in  (ADDR2_FIXED),
		.addr_mask_in (addr_mask_in[1]),
		.rd_sub_out   (rd_sub[1]),
		.rd_data_in   (rd_data[1]),
		.wr_valid_out (wr_valid_out[1]),
		.wr_ready_in  (wr_ready_in[1]),
		.wr_word_out  (wr_word_out[1])
	);
endmodule

// ==== rtl/i2c_link_pkg.sv ====
// constants, types and timing shared by both ends of the two-wire link
package i2c_link_pkg;
	localparam int CLK_MHZ      = 250;
	localparam int STD_HIGH_NS  = 4000;
	localparam int STD_LOW_NS   = 4700;
	localparam int FAST_HIGH_NS = 600;
	localparam int FAST_LOW_NS  = 1300;
	// least times, rounded up to whole cycles
	localparam logic [11:0] STD_HIGH_CYC  = 12'((STD_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] STD_LOW_CYC   = 12'((STD_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] FAST_HIGH_CYC = 12'((FAST_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] FAST_LOW_CYC  = 12'((FAST_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0]  ADDR1_PREFIX  = 4'h4;
	localparam logic [6:0]  ADDR2_FIXED   = 7'h38;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [2:0]  CODE_MAX      = 3'h7;
	// divider ratio band edges on an 8-bit converter scale, lowest first
	localparam logic [6:0][7:0] DEC_THR = {8'hFC, 8'hF2, 8'hE3, 8'hCA, 8'h97, 8'h64, 8'h1A};
	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_ADDR = 3'b001, T_AACK = 3'b011, T_RX = 3'b010,
		T_RACK = 3'b110, T_TX = 3'b111, T_TACK = 3'b101
	} tgt_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_START = 3'b001, M_SEND = 3'b011, M_RECV = 3'b010,
		M_STOP = 3'b110, M_RSTART = 3'b111
	} mst_t;
	typedef enum logic [1:0] {P_LOW = 2'b00, P_RISE = 2'b01, P_HIGH = 2'b11} ph_t;
endpackage

// ==== rtl/i2c_link_if.sv ====
// open-drain clock and data wires joining master and target
`timescale 1ns/1ns
interface i2c_link_if;
	logic t_scl_o;
	logic t_scl_oe;
	logic t_sda_o;
	logic t_sda_oe;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic scl;
	logic sda;
	// pulled up unless some end drives low
	assign scl = ~((t_scl_oe & ~t_scl_o) | (m_scl_oe & ~m_scl_o));
	assign sda = ~((t_sda_oe & ~t_sda_o) | (m_sda_oe & ~m_sda_o));
	modport target (input scl, input sda, output t_scl_o, output t_scl_oe,
		output t_sda_o, output t_sda_oe);
	modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
		output m_sda_o, output m_sda_oe);
endinterface

// ==== rtl/i2c_host_master.sv ====
// master end: drives the link clock and runs register writes and reads
`timescale 1ns/1ns
module i2c_host_master (
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	i2c_link_if.host        link,
	input  wire logic       fast_mode_in,
	input  wire logic       cmd_valid_in,
	output logic            cmd_ready_out,
	input  wire logic       cmd_read_in,
	input  wire logic [6:0] cmd_addr_in,
	input  wire logic [7:0] cmd_sub_in,
	input  wire logic [7:0] cmd_len_in,
	input  wire logic       wdata_valid_in,
	output logic            wdata_ready_out,
	input  wire logic [7:0] wdata_in,
	output logic            rdata_valid_out,
	output logic [7:0]      rdata_out,
	output logic            done_out,
	output logic            nack_out
);
	import i2c_link_pkg::*;
	logic scl1, scl_s, sda1, sda_s;
	logic [11:0] thigh, tlow, cnt_q;
	mst_t st_q;
	ph_t  ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, sub_q, left_q;
	logic [6:0] addr_q;
	logic [1:0] step_q;
	logic rd_q, rdph_q, need_q, ack_q, scl_oe_q, sda_oe_q, drive;
	assign thigh = fast_mode_in ? FAST_HIGH_CYC : STD_HIGH_CYC;
	assign tlow  = fast_mode_in ? FAST_LOW_CYC : STD_LOW_CYC;
	assign cmd_ready_out   = (st_q == M_IDLE) && (cnt_q == thigh);
	assign wdata_ready_out = (st_q == M_SEND) && (ph_q == P_LOW) && need_q;
	assign link.m_scl_o  = 1'b0;
	assign link.m_sda_o  = 1'b0;
	assign link.m_scl_oe = scl_oe_q;
	assign link.m_sda_oe = sda_oe_q;
	// line synchronisers
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
		begin
			{scl1, scl_s} <= 2'h3;
			{sda1, sda_s} <= 2'h3;
		end
		else
		begin
			{scl1, scl_s} <= {link.scl, scl1};
			{sda1, sda_s} <= {link.sda, sda1};
		end
	// data level to hold during a clock low phase
	always_comb
		case (st_q)
			M_SEND:  drive = (bit_q != BYTE_BITS) & ~sh_q[7];
			M_RECV:  drive = (bit_q == BYTE_BITS) & (left_q != 8'h01);
			M_STOP:  drive = 1'b1;
			default: drive = 1'b0;
		endcase
	// transfer sequencer and bit timing
	always_ff @(posedge ref_clk_in)
		if (!resetn_in)
		begin
			st_q <= M_IDLE;
			ph_q <= P_LOW;
			cnt_q <= 12'h000;
			bit_q <= 4'h0;
			{sh_q, sub_q, left_q, addr_q, step_q} <= '0;
			{rd_q, rdph_q, need_q, ack_q, scl_oe_q, sda_oe_q} <= '0;
			{rdata_valid_out, rdata_out, done_out, nack_out} <= '0;
		end
		else
		begin
			rdata_valid_out <= 1'b0;
			done_out <= 1'b0;
			case (st_q)
				M_IDLE:
				begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					if (!(scl_s && sda_s))
						cnt_q <= 12'h000;
					else if (cnt_q != thigh)
						cnt_q <= cnt_q + 12'h001;
					else if (cmd_valid_in)
					begin
						{rd_q, addr_q, sub_q, left_q} <= {cmd_read_in, cmd_addr_in, cmd_sub_in, cmd_len_in};
						{rdph_q, step_q, nack_out} <= '0;
						sda_oe_q <= 1'b1;
						cnt_q <= 12'h000;
						st_q <= M_START;
					end
				end
				M_START:
					if (cnt_q != thigh)
						cnt_q <= cnt_q + 12'h001;
					else
					begin
						scl_oe_q <= 1'b1;
						sh_q <= {addr_q, rdph_q};
						{bit_q, need_q} <= '0;
						ph_q <= P_LOW;
						cnt_q <= 12'h000;
						st_q <= M_SEND;
					end
				default:
					case (ph_q)
						P_LOW:
						begin
							scl_oe_q <= 1'b1;
							if (need_q)
							begin
								if (wdata_valid_in)
								begin
									sh_q <= wdata_in;
									need_q <= 1'b0;
								end
							end
							else
							begin
								sda_oe_q <= drive;
								cnt_q <= cnt_q + 12'h001;
								if (cnt_q == tlow)
									ph_q <= P_RISE;
							end
						end
						P_RISE:
						begin
							scl_oe_q <= 1'b0;
							cnt_q <= 12'h000;
							if (scl_s)
							begin
								ph_q <= P_HIGH;
								if (st_q == M_SEND && bit_q == BYTE_BITS)
									ack_q <= ~sda_s;
								if (st_q == M_RECV && bit_q != BYTE_BITS)
									sh_q <= {sh_q[6:0], sda_s};
							end
						end
						default:
							if (cnt_q != thigh)
								cnt_q <= cnt_q + 12'h001;
							else
							begin
								cnt_q <= 12'h000;
								ph_q <= P_LOW;
								scl_oe_q <= 1'b1;
								if ((st_q == M_SEND || st_q == M_RECV) && bit_q != BYTE_BITS)
								begin
									bit_q <= bit_q + 4'h1;
									if (st_q == M_SEND)
										sh_q <= {sh_q[6:0], 1'b0};
								end
								else
								begin
									bit_q <= 4'h0;
									case (st_q)
										M_SEND:
											if (!ack_q)
											begin
												nack_out <= 1'b1;
												st_q <= M_STOP;
											end
											else if (step_q == 2'h0)
											begin
												if (rdph_q)
													st_q <= M_RECV;
												else
												begin
													sh_q <= sub_q;
													step_q <= 2'h1;
												end
											end
											else if (step_q == 2'h1 && rd_q)
											begin
												rdph_q <= 1'b1;
												step_q <= 2'h0;
												st_q <= M_RSTART;
											end
											else
											begin
												if (step_q == 2'h2)
													left_q <= left_q - 8'h01;
												step_q <= 2'h2;
												if (step_q == 2'h2 && left_q == 8'h01)
													st_q <= M_STOP;
												else
													need_q <= 1'b1;
											end
										M_RECV:
										begin
											rdata_out <= sh_q;
											rdata_valid_out <= 1'b1;
											left_q <= left_q - 8'h01;
											if (left_q == 8'h01)
												st_q <= M_STOP;
										end
										M_STOP:
										begin
											scl_oe_q <= 1'b0;
											sda_oe_q <= 1'b0;
											done_out <= 1'b1;
											st_q <= M_IDLE;
										end
										default:
										begin
											scl_oe_q <= 1'b0;
											sda_oe_q <= 1'b1;
											st_q <= M_START;
										end
									endcase
								end
							end
					endcase
			endcase
		end
endmodule

// ==== bench/i2c_link_monitor.sv ====
// concurrent checks on the first master to target link
`timescale 1ns/1ns
module i2c_link_monitor (
	input  wire logic ref_clk_in,
	input  wire logic resetn_in,
	input  wire logic t_scl_o,
	input  wire logic t_scl_oe,
	input  wire logic t_sda_o,
	input  wire logic t_sda_oe,
	input  wire logic m_scl_o,
	input  wire logic m_scl_oe,
	input  wire logic m_sda_o,
	input  wire logic m_sda_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       busy_q;
	logic [3:0] bit_q;
	logic       start_w;
	logic       stop_w;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// previous line levels
	always_ff @(posedge ref_clk_in)
	begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// data edges while the clock stays high
	assign start_w = scl & scl_q & sda_q & ~sda;
	assign stop_w  = scl & scl_q & ~sda_q & sda;
	// transfer open between start and stop
	always_ff @(posedge ref_clk_in)
	begin
		if (!resetn_in)
			busy_q <= 1'h0;
		else if (start_w)
			busy_q <= 1'h1;
		else if (stop_w)
			busy_q <= 1'h0;
	end
	// clock rises modulo nine since start
	always_ff @(posedge ref_clk_in)
	begin
		if (!resetn_in || start_w)
			bit_q <= 4'h0;
		else if (scl && !scl_q)
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
	end
	sequence s_ack_held;
		t_sda_oe [*8];
	endsequence
	sequence s_high_hold;
		!m_scl_oe [*8];
	endsequence
	a_open_drain_lvl: assert property (!(t_scl_o | t_sda_o | m_scl_o | m_sda_o))
		else $error("open-drain data not low");
	a_tgt_sda_stable: assert property ($changed(t_sda_oe) |-> !scl && !$past(scl))
		else $error("target data moved in clock high");
	a_ack_held: assert property ($rose(scl) && t_sda_oe |-> s_ack_held)
		else $error("target low not held in clock high");
	a_no_dual_drive: assert property ($rose(scl) |-> !(t_sda_oe && m_sda_oe))
		else $error("both ends pull data at clock rise");
	a_byte_framing: assert property ((start_w || stop_w) && busy_q |-> bit_q == 4'h1)
		else $error("transfer not whole bytes");
	a_idle_released: assert property (!busy_q |-> !t_sda_oe && !t_scl_oe)
		else $error("target drives idle bus");
	a_stretch_in_low: assert property ($rose(t_scl_oe) |-> !$past(scl))
		else $error("stretch began in clock high");
	a_high_min: assert property ($rose(scl) |-> s_high_hold)
		else $error("clock high too short");
endmodule

// ==== bench/tb_top.sv ====
// bench: two masters drive the two target ports
`timescale 1ns/1ns
module tb_top;
	logic             ref_clk_in;
	logic             resetn_in;
	logic [7:0]       pin;
	logic             port_en;
	logic [1:0][6:0]  amask;
	logic             rw_en;
	logic [7:0]       rw_idx;
	logic [7:0]       rw_data;
	logic [1:0]       wr_valid;
	logic [1:0]       wr_ready;
	logic [1:0][15:0] wr_word;
	logic [7:0]       ev;
	logic [1:0][7:0]  imask;
	logic [1:0]       irq;
	logic [1:0]       fast;
	logic [1:0]       cvalid;
	logic [1:0]       cready;
	logic [1:0]       cread;
	logic [1:0]       wvalid;
	logic [1:0]       wready;
	logic [1:0]       rvalid;
	logic [1:0]       done;
	logic [1:0]       nack;
	logic [6:0]       caddr [2];
	logic [7:0]       csub [2];
	logic [7:0]       clen [2];
	logic [7:0]       wdata [2];
	logic [7:0]       rdata [2];
	logic [7:0]       rd_q [$];
	int               done_n [2];
	int               checks;
	int               miscompares;
	int               cycles;
	logic             sda_seen;
	logic             scl_seen;
	i2c_link_if link [2] ();
	i2c_target_ports u_i2c_target_ports (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .first_target_port(link[0]),
		.second_target_port(link[1]), .address_select_analog_pin_in(pin),
		.port_en_in(port_en), .addr_mask_in(amask), .reg_wr_en_in(rw_en),
		.reg_wr_idx_in(rw_idx), .reg_wr_data_in(rw_data), .wr_valid_out(wr_valid),
		.wr_ready_in(wr_ready), .wr_word_out(wr_word), .event_in(ev),
		.irq_mask_in(imask), .irq_out(irq)
	);
	// one master per target port
	for (genvar g = 0; g < 2; g++)
	begin : gen_host
		i2c_host_master u_i2c_host_master (
			.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(link[g]),
			.fast_mode_in(fast[g]), .cmd_valid_in(cvalid[g]), .cmd_ready_out(cready[g]),
			.cmd_read_in(cread[g]), .cmd_addr_in(caddr[g]), .cmd_sub_in(csub[g]),
			.cmd_len_in(clen[g]), .wdata_valid_in(wvalid[g]), .wdata_ready_out(wready[g]),
			.wdata_in(wdata[g]), .rdata_valid_out(rvalid[g]), .rdata_out(rdata[g]),
			.done_out(done[g]), .nack_out(nack[g])
		);
	end
	i2c_link_monitor u_i2c_link_monitor (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .t_scl_o(link[0].t_scl_o),
		.t_scl_oe(link[0].t_scl_oe), .t_sda_o(link[0].t_sda_o), .t_sda_oe(link[0].t_sda_oe),
		.m_scl_o(link[0].m_scl_o), .m_scl_oe(link[0].m_scl_oe), .m_sda_o(link[0].m_sda_o),
		.m_sda_oe(link[0].m_sda_oe), .scl(link[0].scl), .sda(link[0].sda)
	);
	initial
	begin
		ref_clk_in = 1'h0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	// ceiling above the roughly 85k cycles of traffic
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 99000)
		begin
			miscompares++;
			finish_test;
		end
	end
	// collect pulses and target line activity
	always @(posedge ref_clk_in)
	begin
		if (done[0] === 1'h1) done_n[0]++;
		if (done[1] === 1'h1) done_n[1]++;
		if (rvalid[0] === 1'h1) rd_q.push_back(rdata[0]);
		if (link[0].t_sda_oe === 1'h1) sda_seen = 1'h1;
		if (link[0].t_scl_oe === 1'h1) scl_seen = 1'h1;
	end
	task automatic tick;
		@(posedge ref_clk_in);
		#1;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_set(input logic [7:0] idx, input logic [7:0] dat);
		rw_en = 1'h1;
		rw_idx = idx;
		rw_data = dat;
		tick;
		rw_en = 1'h0;
		tick;
	endtask
	// one command; written bytes count up from w0
	task automatic xfer(input int p, input logic rd, input logic [6:0] a,
		input logic [7:0] s, input logic [7:0] n, input logic [7:0] w0);
		int k;
		int d0;
		d0 = done_n[p];
		cvalid[p] = 1'h1;
		cread[p] = rd;
		caddr[p] = a;
		csub[p] = s;
		clen[p] = n;
		for (k = 0; cready[p] !== 1'h1 && k < 9000; k++) tick;
		tick;
		cvalid[p] = 1'h0;
		for (int i = 0; i < n && !rd; i++)
		begin
			wvalid[p] = 1'h1;
			wdata[p] = w0 + 8'(i);
			for (k = 0; wready[p] !== 1'h1 && k < 60000; k++) tick;
			tick;
		end
		wvalid[p] = 1'h0;
		for (k = 0; done_n[p] == d0 && k < 60000; k++) tick;
	endtask
	task automatic pop(input int p, input logic [15:0] exp);
		int k;
		for (k = 0; wr_valid[p] !== 1'h1 && k < 60000; k++) tick;
		cmp(wr_word[p], exp);
		wr_ready[p] = 1'h1;
		tick;
		wr_ready[p] = 1'h0;
		tick;
	endtask
	initial
	begin
		resetn_in = 1'h0;
		port_en = 1'h0;
		pin = 8'h20;
		amask = '0;
		rw_en = 1'h0;
		rw_idx = 8'h0;
		rw_data = 8'h0;
		wr_ready = 2'h0;
		ev = 8'h0;
		imask = '0;
		fast = 2'h3;
		cvalid = 2'h0;
		cread = 2'h0;
		wvalid = 2'h0;
		caddr = '{7'h0, 7'h0};
		csub = '{8'h0, 8'h0};
		clen = '{8'h1, 8'h1};
		wdata = '{8'h0, 8'h0};
		sda_seen = 1'h0;
		scl_seen = 1'h0;
		repeat (4) @(posedge ref_clk_in);
		#1 resetn_in = 1'h1;
		reg_set(8'h05, 8'hA5);
		reg_set(8'h06, 8'h3C);
		// ports disabled: no answer
		xfer(0, 1'h1, 7'h21, 8'h05, 8'h1, 8'h0);
		cmp(16'(nack[0]), 16'h1);
		cmp(16'(sda_seen), 16'h0);
		port_en = 1'h1;
		tick;
		pin = 8'hFF;
		// standard speed, foreign address
		fast[0] = 1'h0;
		xfer(0, 1'h1, 7'h22, 8'h05, 8'h1, 8'h0);
		cmp(16'(nack[0]), 16'h1);
		cmp(16'(sda_seen), 16'h0);
		fast[0] = 1'h1;
		amask[1] = 7'h01;
		// five bytes into a four-word fifo, second port in parallel
		fork
			xfer(0, 1'h0, 7'h21, 8'h02, 8'h5, 8'h10);
			xfer(1, 1'h0, 7'h39, 8'h07, 8'h1, 8'h5A);
			begin
				for (int k = 0; scl_seen !== 1'h1 && k < 60000; k++) tick;
				for (int i = 0; i < 5; i++) pop(0, {8'h02 + 8'(i), 8'h10 + 8'(i)});
			end
			pop(1, 16'h075A);
		join
		cmp(16'(scl_seen), 16'h1);
		cmp(16'(nack[0]), 16'h0);
		cmp(16'(nack[1]), 16'h0);
		// register read across a repeated start
		rd_q.delete();
		xfer(0, 1'h1, 7'h21, 8'h05, 8'h2, 8'h0);
		cmp(16'(rd_q.size()), 16'h2);
		cmp(16'(rd_q[0]), 16'hA5);
		cmp(16'(rd_q[1]), 16'h3C);
		cmp(16'(nack[0]), 16'h0);
		// per-port event masks
		ev = 8'h81;
		imask[0] = 8'h01;
		imask[1] = 8'h80;
		tick;
		cmp(16'(irq), 16'h3);
		imask[1] = 8'h00;
		tick;
		cmp(16'(irq), 16'h1);
		finish_test;
	end
endmodule
